// ==== src/rss_pkg.sv ====
package rss_pkg;

  // Clock and time base
  localparam int CLK_PERIOD_PS = 25000;
  localparam int MS_PS         = 1000000000;
  localparam int TICK_CYC      = MS_PS / CLK_PERIOD_PS;

  // Press timing, in milliseconds
  localparam int LONG_PRESS_MS = 500;
  localparam int ONE_BTN_MS    = 3000;
  localparam int DEAD_MS       = 500;
  localparam int RND_MAX_MS    = 1000;

  // Programmed run time, in seconds
  localparam int RUN_MIN_S     = 1;
  localparam int RUN_MAX_S     = 900;
  localparam int MS_PER_S      = 1000;
  localparam int RUN_SEC_W     = 10;

  // Counter widths
  localparam int CNT_W         = 20;
  localparam int GAP_W         = 10;
  localparam int OB_W          = 12;
  localparam int RND_W         = 10;
  localparam int LFSR_W        = 16;

  // Random source
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS = 16'hB400;

  // Synchroniser bit positions
  localparam int PIN_LOC_UP    = 0;
  localparam int PIN_LOC_DN    = 1;
  localparam int PIN_CEN_UP    = 2;
  localparam int PIN_CEN_DN    = 3;
  localparam int PIN_SEC_LSB   = 4;
  localparam int SYNC_W        = 4 + RUN_SEC_W;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DELAY,
    ST_PRESS,
    ST_HELD,
    ST_TIMED
  } rss_state_t;

endpackage

// ==== src/rss_sync.sv ====
`timescale 1ns/1ps
module rss_sync
#(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= RST_VAL;
      q_r    <= RST_VAL;
    end
    else
    begin
      meta_r <= d;
      q_r    <= meta_r;
    end
  end

  assign q = q_r;

endmodule

// ==== src/rss_sequencer.sv ====
// Summary of operation
// - Motor runs for programmed 1 s to 15 min
// - Short press runs full time after release
// - Press while moving stops motor at once
// - Long press runs only while button held
// - Lower held permanently selects one-button mode
// - One-button presses alternate direction each run
// - Central inputs start only their own direction
// - Central run ends on timeout or local press
// - Held central lower closes, locks other inputs
// - Direction memory shared by local and central
// - Central starts delayed randomly up to 1 s
`timescale 1ns/1ps
module rss_sequencer
  import rss_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)
(
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  input  wire logic                 loc_up_n,
  input  wire logic                 loc_down_n,
  input  wire logic                 cen_up_n,
  input  wire logic                 cen_down_n,
  input  wire logic [RUN_SEC_W-1:0] run_sec,
  output logic                      motor_up,
  output logic                      motor_down,
  output logic                      one_btn_mode,
  output logic                      lock_active
);

  localparam int TW = $clog2(TICK_CYCLES + 1);

  logic [SYNC_W-1:0] sync_q;
  logic [3:0]        prev_r;
  logic [TW-1:0]     tick_cnt_r;
  logic [OB_W-1:0]   ob_cnt_r;
  logic              one_btn_r;
  logic [LFSR_W-1:0] lfsr_r;
  logic [RND_W-1:0]  rnd_r;
  logic [CNT_W-1:0]  cnt_r;
  logic [GAP_W-1:0]  gap_r;
  rss_state_t        state_r;
  rss_state_t        state_nxt;
  logic              dir_r;
  logic              dir_nxt;
  logic              last_r;
  logic              last_nxt;
  logic              clr;
  logic              motor_up_r;
  logic              motor_dn_r;
  logic              lock_r;

  rss_sync
  #(
    .W       (SYNC_W),
    .RST_VAL ({{RUN_SEC_W{1'b0}}, 4'hF})
  )
  u_sync
  (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     ({run_sec, cen_down_n, cen_up_n, loc_down_n, loc_up_n}),
    .q     (sync_q)
  );

  // Active-high button levels after synchronisation
  wire [3:0] lvl      = ~sync_q[3:0];
  wire       loc_up   = lvl[PIN_LOC_UP];
  wire       loc_dn   = lvl[PIN_LOC_DN];
  wire       cen_up   = lvl[PIN_CEN_UP];
  wire       cen_dn   = lvl[PIN_CEN_DN];
  wire [3:0] rise     = lvl & ~prev_r;
  wire [RUN_SEC_W-1:0] sec_s = sync_q[PIN_SEC_LSB +: RUN_SEC_W];

  wire tick = (tick_cnt_r == TW'(TICK_CYCLES - 1));

  // Run time clamped to the legal range, in ms
  wire [RUN_SEC_W-1:0] run_s =
    (sec_s < RUN_SEC_W'(RUN_MIN_S)) ? RUN_SEC_W'(RUN_MIN_S) :
    (sec_s > RUN_SEC_W'(RUN_MAX_S)) ? RUN_SEC_W'(RUN_MAX_S) : sec_s;
  wire [CNT_W-1:0] run_ms = CNT_W'(run_s * MS_PER_S);

  // Random start delay kept within the limit
  wire [RND_W-1:0] rnd_val =
    (lfsr_r[RND_W-1:0] > RND_W'(RND_MAX_MS - 1)) ?
    {1'b0, lfsr_r[RND_W-2:0]} : lfsr_r[RND_W-1:0];

  // Local press events and held levels
  wire loc_ev  = rise[PIN_LOC_UP] | (rise[PIN_LOC_DN] & ~one_btn_r);
  wire loc_dir = one_btn_r ? ~last_r : rise[PIN_LOC_UP];
  wire hold    = one_btn_r ? loc_up : (dir_r ? loc_up : loc_dn);
  wire moving  = (state_r != ST_IDLE);
  wire timed_out = tick && (cnt_r >= run_ms - CNT_W'(1));

  wire run_st  = (state_r == ST_PRESS) || (state_r == ST_HELD) ||
                 (state_r == ST_TIMED);
  wire run_up  = run_st & dir_r;
  wire run_dn  = run_st & ~dir_r;
  wire gap_ok  = (gap_r >= GAP_W'(DEAD_MS));
  wire up_nxt  = run_up & (motor_up_r | (~motor_dn_r & gap_ok));
  wire dn_nxt  = run_dn & (motor_dn_r | (~motor_up_r & gap_ok));

  always_comb
  begin
    state_nxt = state_r;
    dir_nxt   = dir_r;
    last_nxt  = last_r;
    clr       = 1'b0;
    if (rise[PIN_CEN_DN])
    begin
      state_nxt = ST_DELAY;
      dir_nxt   = 1'b0;
      last_nxt  = 1'b0;
      clr       = 1'b1;
    end
    else if (rise[PIN_CEN_UP] && !cen_dn)
    begin
      state_nxt = ST_DELAY;
      dir_nxt   = 1'b1;
      last_nxt  = 1'b1;
      clr       = 1'b1;
    end
    else if (loc_ev && !cen_dn)
    begin
      clr = 1'b1;
      if (moving)
        state_nxt = ST_IDLE;
      else
      begin
        state_nxt = ST_PRESS;
        dir_nxt   = loc_dir;
        last_nxt  = loc_dir;
      end
    end
    else
    begin
      case (state_r)
        ST_IDLE:
          state_nxt = ST_IDLE;
        ST_DELAY:
          if (tick && cnt_r >= CNT_W'(rnd_r))
          begin
            state_nxt = ST_TIMED;
            clr       = 1'b1;
          end
        ST_PRESS:
          if (!hold)
          begin
            state_nxt = ST_TIMED;
            clr       = 1'b1;
          end
          else if (tick && cnt_r >= CNT_W'(LONG_PRESS_MS - 1))
            state_nxt = ST_HELD;
        ST_HELD:
          if (!hold)
            state_nxt = ST_IDLE;
        ST_TIMED:
          if (timed_out)
            state_nxt = ST_IDLE;
        default:
          state_nxt = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_r     <= 4'h0;
      tick_cnt_r <= '0;
      lfsr_r     <= LFSR_SEED;
    end
    else
    begin
      prev_r     <= lvl;
      tick_cnt_r <= tick ? '0 : tick_cnt_r + TW'(1);
      lfsr_r     <= lfsr_r[0] ? ((lfsr_r >> 1) ^ LFSR_TAPS) : (lfsr_r >> 1);
    end
  end

  // One-button wiring: lower input held beyond the qualify time
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ob_cnt_r  <= '0;
      one_btn_r <= 1'b0;
    end
    else if (!loc_dn)
    begin
      ob_cnt_r  <= '0;
      one_btn_r <= 1'b0;
    end
    else if (tick && !one_btn_r)
    begin
      ob_cnt_r  <= ob_cnt_r + OB_W'(1);
      one_btn_r <= (ob_cnt_r >= OB_W'(ONE_BTN_MS - 1));
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= ST_IDLE;
      dir_r   <= 1'b0;
      last_r  <= 1'b0;
      rnd_r   <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      dir_r   <= dir_nxt;
      last_r  <= last_nxt;
      rnd_r   <= (state_r == ST_DELAY) ? rnd_r : rnd_val;
    end
  end

  // Millisecond counter for the current state
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_r <= '0;
    else if (clr)
      cnt_r <= '0;
    else if (tick && cnt_r != {CNT_W{1'b1}})
      cnt_r <= cnt_r + CNT_W'(1);
  end

  // Stopped time since the motor was last driven
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      gap_r <= GAP_W'(DEAD_MS);
    else if (motor_up_r || motor_dn_r)
      gap_r <= '0;
    else if (tick && !gap_ok)
      gap_r <= gap_r + GAP_W'(1);
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      motor_up_r <= 1'b0;
      motor_dn_r <= 1'b0;
      lock_r     <= 1'b0;
    end
    else
    begin
      motor_up_r <= up_nxt;
      motor_dn_r <= dn_nxt;
      lock_r     <= cen_dn;
    end
  end

  assign motor_up     = motor_up_r;
  assign motor_down   = motor_dn_r;
  assign one_btn_mode = one_btn_r;
  assign lock_active  = lock_r;

endmodule

// ==== testbench/rss_assertions.sv ====
`timescale 1ns/1ps
module rss_assertions
  import rss_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic loc_up_n,
  input wire logic loc_down_n,
  input wire logic cen_down_n,
  input wire logic motor_up,
  input wire logic motor_down,
  input wire logic one_btn_mode,
  input wire logic lock_active
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence down_hit_s;
    $fell(loc_down_n) ##0 (motor_up && !lock_active);
  endsequence
  sequence up_hit_s;
    $fell(loc_up_n) ##0 (motor_down && !lock_active);
  endsequence
  both_off_a: assert property (!(motor_up && motor_down))
    else $error("raise and lower both on");
  up_gap_a: assert property ($fell(motor_up) |=> !motor_down [*8])
    else $error("lower right after raise");
  down_gap_a: assert property ($fell(motor_down) |=> !motor_up [*8])
    else $error("raise right after lower");
  stop_down_a: assert property (down_hit_s |-> ##[1:6] !motor_up)
    else $error("raise not stopped");
  stop_up_a: assert property (up_hit_s |-> ##[1:6] !motor_down)
    else $error("lower not stopped");
  lock_rise_a: assert property ($fell(cen_down_n) |-> ##[1:6] lock_active)
    else $error("lock not taken");
  lock_cause_a: assert property ($rose(lock_active) |-> !$past(cen_down_n, 2))
    else $error("lock without input");
  lock_hold_a: assert property (lock_active [*3] |-> !motor_up)
    else $error("raise while locked");
  mode_cause_a: assert property ($rose(one_btn_mode) |-> !$past(loc_down_n, 8))
    else $error("mode without held lower");
endmodule

// ==== testbench/rss_panel.sv ====
`timescale 1ns/1ps
module rss_panel
(
  input  wire logic       mclk,
  input  wire logic [3:0] want,
  output logic [3:0]      pin_n
);
  // Open contact reads high, closed contact pulls low
  always @(posedge mclk) pin_n <= #1 ~want;
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
module tb;
  import rss_pkg::*;
  localparam int TK  = 4;
  localparam int GAP = DEAD_MS * TK + 40;
  localparam int RND = (RND_MAX_MS + 1) * TK + 16;
  // Watchdog span: one-button qualify, longest runs, all gaps and delays
  localparam int LIMIT = (ONE_BTN_MS + 4 * MS_PER_S) * TK + 10 * GAP + 6 * RND;
  logic                 mclk    = 1'b0;
  logic                 rst_n   = 1'b0;
  logic [3:0]           want    = 4'h0;
  logic [3:0]           pin_n;
  logic [RUN_SEC_W-1:0] run_sec = 10'h000;
  logic                 motor_up, motor_down, one_btn_mode, lock_active;
  logic [31:0]          seed    = 32'h0001_1568;
  int                   miscompares = 0;
  int                   tests_run = 0;
  int                   n;
  always #12.5 mclk = ~mclk;
  rss_panel pnl (.mclk(mclk), .want(want), .pin_n(pin_n));
  rss_sequencer #(.TICK_CYCLES(TK)) uut (.mclk(mclk), .rst_n(rst_n), .loc_up_n(pin_n[0]),
    .loc_down_n(pin_n[1]), .cen_up_n(pin_n[2]), .cen_down_n(pin_n[3]), .run_sec(run_sec),
    .motor_up(motor_up), .motor_down(motor_down), .one_btn_mode(one_btn_mode),
    .lock_active(lock_active));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic int run_cyc(input int s);
    return ((s < RUN_MIN_S) ? RUN_MIN_S : (s > RUN_MAX_S) ? RUN_MAX_S : s) * MS_PER_S * TK;
  endfunction
  task automatic cyc(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: %s got %0d want %0d", $time, what, got, exp);
    end
  endtask
  task hit(input int k, input int ms);
    want[k] = 1'b1;
    cyc(ms * TK);
    want[k] = 1'b0;
    cyc(8);
  endtask
  task wait_mot(input bit dn, input int lim, input logic lvl);
    n = 0;
    while ((dn ? motor_down : motor_up) !== lvl && n < lim)
    begin
      cyc(1);
      n++;
    end
  endtask
  task end_of_test;
    $display("checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (LIMIT) @(posedge mclk);
    #1;
    miscompares++;
    end_of_test;
  end
  initial
  begin
    cyc(16);
    rst_n = 1'b1;
    chk({motor_up, motor_down, one_btn_mode, lock_active}, 4'h0, "reset");
    hit(0, 50);
    chk(motor_up, 1'b1, "short start");
    wait_mot(0, run_cyc(0) + 40, 1'b0);
    chk(n > run_cyc(0) - 48 && motor_up === 1'b0, 1'b1, "clamped run");
    $display("test 1 end");
    cyc(GAP);
    seed = xs(seed);
    run_sec = 10'(1 + seed[0]);
    hit(0, 50);
    hit(1, 50);
    chk({motor_up, motor_down}, 2'h0, "stop");
    $display("test 2 end");
    cyc(GAP);
    seed = xs(seed);
    want[1] = 1'b1;
    cyc((600 + seed[6:0]) * TK);
    chk(motor_down, 1'b1, "long held");
    want[1] = 1'b0;
    cyc(10);
    chk(motor_down, 1'b0, "long release");
    $display("test 3 end");
    cyc(GAP);
    hit(2, 5);
    wait_mot(0, RND, 1'b1);
    chk(n < RND && motor_down === 1'b0, 1'b1, "central raise delay");
    cyc(400);
    hit(1, 50);
    chk(motor_up, 1'b0, "central ended by local");
    $display("test 4 end");
    cyc(GAP);
    want[3] = 1'b1;
    wait_mot(1, RND, 1'b1);
    hit(0, 50);
    chk({lock_active, motor_up, motor_down}, 3'h5, "locked");
    want[3] = 1'b0;
    cyc(10);
    chk(lock_active, 1'b0, "unlock");
    wait_mot(1, run_cyc(run_sec) + RND, 1'b0);
    chk(motor_down, 1'b0, "locked run ends");
    $display("test 5 end");
    cyc(GAP);
    want[1] = 1'b1;
    cyc(ONE_BTN_MS * TK + 40);
    chk({one_btn_mode, motor_down}, 2'h2, "one button mode");
    cyc(GAP);
    hit(2, 5);
    wait_mot(0, RND, 1'b1);
    chk(motor_up, 1'b1, "central raise");
    hit(0, 50);
    cyc(GAP);
    hit(0, 50);
    chk(motor_down, 1'b1, "memory after central");
    hit(0, 50);
    chk(motor_down, 1'b0, "single stop");
    cyc(GAP);
    hit(0, 50);
    chk(motor_up, 1'b1, "alternate");
    hit(0, 50);
    want[1] = 1'b0;
    cyc(10);
    chk(one_btn_mode, 1'b0, "mode release");
    $display("test 6 end");
    end_of_test;
  end
endmodule

bind rss_sequencer rss_assertions #(.TICK_CYCLES(TICK_CYCLES)) chk_i (.mclk(mclk),
  .rst_n(rst_n), .loc_up_n(loc_up_n), .loc_down_n(loc_down_n), .cen_down_n(cen_down_n),
  .motor_up(motor_up), .motor_down(motor_down), .one_btn_mode(one_btn_mode),
  .lock_active(lock_active));
